/* File: rtl/fmon_monitor.sv */
// fault report monitor: shared pending vector and capture structures
// assumes sources, software and power control share core_clk
`timescale 1ns/1ps
// What this block does
// - one shared pending bit per each of 96 sources
// - every structure reads the same pending vector
// - source index n maps to word n/32, bit n%32
// - capture clears that source's pending bit
// - three mask words select eligible faults per structure
// - masks are separate storage per structure
// - lowest structure wins a shared pending fault
// - capture only while valid flag is zero
// - capture sets valid and clears pending together
// - capture ignores interrupt flag; firmware clears it
// - deep sleep resets source interface and pending
// - pending and interrupt state lost in deep sleep
// - control, masks, gate survive sleep, not system reset
// - of the resets, only hard reset clears status and data; status write clears valid
// - faults also reported as bus errors to initiator
// - interrupt set on capture, write one clears, gated
// - dma trigger is valid and trigger enable
// - fault output follows valid when output enabled
// - gated reset requests ORed into one request
module fmon_monitor (
  input  wire logic                                    core_clk,
  input  wire logic                                    rst_n,
  input  wire logic                                    sys_rst,
  input  wire logic                                    deep_sleep,
  input  wire logic [fmon_pkg::NSRC-1:0]               fault_set,
  input  wire fmon_pkg::fmon_info_t [fmon_pkg::NSRC-1:0] fault_info,
  input  wire fmon_pkg::fmon_cmd_t [fmon_pkg::NSTRUCT-1:0] sw_cmd,
  output fmon_pkg::fmon_view_t [fmon_pkg::NSTRUCT-1:0] sw_view,
  output logic [fmon_pkg::NSRC-1:0]                    fault_ack,
  output logic [fmon_pkg::NSRC-1:0]                    bus_err,
  output logic                                         soft_reset_req
);
  import fmon_pkg::*;

  logic [NSRC-1:0]          pending_reg;
  logic [NSRC-1:0]          pending_next;
  logic [NSRC-1:0]          ack_reg;
  logic [NSRC-1:0]          bus_err_reg;
  logic                     rst_req_reg;
  logic [NSTRUCT-1:0][2:0]  ctl_reg;
  logic [NSTRUCT-1:0][NSRC-1:0] mask_reg;
  logic [NSTRUCT-1:0]       gate_reg;
  logic [NSTRUCT-1:0]       irq_reg;
  logic [NSTRUCT-1:0]       irq_gated_reg;
  logic [NSTRUCT-1:0]       trig_reg;
  logic [NSTRUCT-1:0]       fout_reg;
  logic [NSTRUCT-1:0]       valid_reg;
  logic [NSTRUCT-1:0][IDX_W-1:0] idx_reg;
  fmon_info_t [NSTRUCT-1:0] info_reg;
  logic [NSTRUCT-1:0]       cap;
  logic [NSTRUCT-1:0][IDX_W-1:0] cap_idx;
  logic [NSRC-1:0]          taken;

  // lowest set bit of a vector
  function automatic logic [IDX_W-1:0] low_index(input logic [NSRC-1:0] v);
    logic [IDX_W-1:0] r;
    r = '0;
    for (int i = NSRC - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = IDX_W'(i);
      end
    end
    return r;
  endfunction : low_index

  // fixed precedence arbitration across structures
  always_comb begin
    logic [NSRC-1:0] avail;
    logic [NSRC-1:0] elig;
    avail = pending_reg;
    elig = '0;
    taken = '0;
    cap = '0;
    cap_idx = '0;
    for (int s = 0; s < NSTRUCT; s++) begin
      elig = avail & mask_reg[s];
      cap[s] = !valid_reg[s] && (|elig) && !deep_sleep;
      cap_idx[s] = low_index(elig);
      if (cap[s]) begin
        taken[cap_idx[s]] = 1'b1;
        avail[cap_idx[s]] = 1'b0;
      end
    end
  end

  // new fault wins over a capture clear of the same bit
  always_comb begin
    pending_next = (pending_reg & ~taken) | fault_set;
  end

  // shared pending vector, active domain
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pending_reg <= '0;
    end else if (sys_rst || deep_sleep) begin
      pending_reg <= '0;
    end else begin
      pending_reg <= pending_next;
    end
  end

  // source interface acknowledge and bus error reporting
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_reg     <= '0;
      bus_err_reg <= '0;
    end else if (sys_rst || deep_sleep) begin
      ack_reg     <= '0;
      bus_err_reg <= '0;
    end else begin
      ack_reg     <= taken;
      bus_err_reg <= fault_set;
    end
  end

  // one combined soft reset request
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_req_reg <= 1'b0;
    end else begin
      rst_req_reg <= 1'b0;
      for (int s = 0; s < NSTRUCT; s++) begin
        if (valid_reg[s] && ctl_reg[s][CTL_RST]) begin
          rst_req_reg <= 1'b1;
        end
      end
    end
  end

  for (genvar s = 0; s < NSTRUCT; s++) begin : g_struct
    // control, masks and gate: kept in sleep, cleared by system reset
    always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
        ctl_reg[s]  <= CTL_RESET;
        mask_reg[s] <= MASK_RESET;
        gate_reg[s] <= 1'b0;
      end else if (sys_rst) begin
        ctl_reg[s]  <= CTL_RESET;
        mask_reg[s] <= MASK_RESET;
        gate_reg[s] <= 1'b0;
      end else begin
        if (sw_cmd[s].ctl_we) begin
          ctl_reg[s] <= sw_cmd[s].ctl;
        end
        if (sw_cmd[s].mask_we) begin
          mask_reg[s] <= sw_cmd[s].mask;
        end
        if (sw_cmd[s].gate_we) begin
          gate_reg[s] <= sw_cmd[s].gate;
        end
      end
    end

    // status and captured data: of the resets, hard reset only; status_clr also clears valid
    always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
        valid_reg[s] <= 1'b0;
        idx_reg[s]   <= '0;
        info_reg[s]  <= '0;
      end else if (cap[s]) begin
        valid_reg[s] <= 1'b1;
        idx_reg[s]   <= cap_idx[s];
        info_reg[s]  <= fault_info[cap_idx[s]];
      end else if (sw_cmd[s].status_clr) begin
        valid_reg[s] <= 1'b0;
      end
    end

    // interrupt flag: capture or force set, write one clears
    always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
        irq_reg[s] <= 1'b0;
      end else if (sys_rst || deep_sleep) begin
        irq_reg[s] <= 1'b0;
      end else if (cap[s] || sw_cmd[s].irq_force) begin
        irq_reg[s] <= 1'b1;
      end else if (sw_cmd[s].irq_clr) begin
        irq_reg[s] <= 1'b0;
      end
    end

    // registered signalling outputs
    always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
        irq_gated_reg[s] <= 1'b0;
        trig_reg[s]      <= 1'b0;
        fout_reg[s]      <= 1'b0;
      end else begin
        irq_gated_reg[s] <= irq_reg[s] & gate_reg[s];
        trig_reg[s]      <= valid_reg[s] & ctl_reg[s][CTL_TRIG];
        fout_reg[s]      <= valid_reg[s] & ctl_reg[s][CTL_OUT];
      end
    end

    always_comb begin
      sw_view[s].status = {valid_reg[s], 24'h0, idx_reg[s]};
      sw_view[s].info = info_reg[s];
      sw_view[s].ctl = ctl_reg[s];
      sw_view[s].mask = mask_reg[s];
      sw_view[s].gate = gate_reg[s];
      sw_view[s].irq = irq_reg[s];
      sw_view[s].irq_gated = irq_gated_reg[s];
      sw_view[s].dma_trigger_out = trig_reg[s];
      sw_view[s].fault_out = fout_reg[s];
      sw_view[s].pending_fault_vector = pending_reg;
    end
  end

  assign fault_ack      = ack_reg;
  assign bus_err        = bus_err_reg;
  assign soft_reset_req = rst_req_reg;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  a_capture_clears_pending: assert property (
    cap[0] && !fault_set[cap_idx[0]] && !sys_rst && !deep_sleep
      |=> !pending_reg[$past(cap_idx[0])])
    else $error("captured fault still pending");
  a_valid_blocks_cap: assert property (
    valid_reg[1] |-> !cap[1])
    else $error("capture while valid set");
  a_capture_sets_valid: assert property (
    cap[1] |=> valid_reg[1] && idx_reg[1] == $past(cap_idx[1]))
    else $error("valid or index not latched on capture");
  a_lower_wins: assert property (
    cap[0] && cap[1] |-> cap_idx[0] != cap_idx[1])
    else $error("two structures took one fault");
  a_pending_needs_mask: assert property (
    cap[0] |-> mask_reg[0][cap_idx[0]] && pending_reg[cap_idx[0]])
    else $error("capture of a disabled or absent fault");
  a_sleep_clears: assert property (
    deep_sleep |=> pending_reg == '0 && irq_reg == '0)
    else $error("pending or irq kept in deep sleep");
  a_irq_on_capture: assert property (
    cap[0] ##1 gate_reg[0] |=> irq_gated_reg[0])
    else $error("gated interrupt missing after capture");
  a_trigger_follows: assert property (
    valid_reg[0] && ctl_reg[0][CTL_TRIG] |=> trig_reg[0])
    else $error("dma trigger missing");
  a_fault_out_follows: assert property (
    $fell(valid_reg[1]) |=> !fout_reg[1])
    else $error("fault output stays after valid cleared");
  a_reset_req_or: assert property (
    soft_reset_req |-> $past(|(valid_reg & {ctl_reg[1][CTL_RST],
                                            ctl_reg[0][CTL_RST]})))
    else $error("reset request without cause");
  a_lowest_first: assert property (
    cap[0] |-> ((pending_reg & mask_reg[0]) &
                ((96'h1 << cap_idx[0]) - 96'h1)) == '0)
    else $error("capture skipped a lower index");
  a_ack_after_capture: assert property (
    cap[0] && !sys_rst |=> fault_ack[$past(cap_idx[0])])
    else $error("no acknowledge after capture");
  a_bus_err_copy: assert property (
    !sys_rst && !deep_sleep |=> bus_err == $past(fault_set))
    else $error("bus error does not follow fault event");
  a_sleep_no_capture: assert property (
    deep_sleep |-> cap == '0)
    else $error("capture during deep sleep");
  a_status_kept_sysrst: assert property (
    sys_rst && !cap[0] && !sw_cmd[0].status_clr |=> $stable(valid_reg[0]))
    else $error("status lost on system reset");
  a_ctl_sysrst_clear: assert property (
    sys_rst |=> ctl_reg[0] == CTL_RESET && mask_reg[0] == MASK_RESET)
    else $error("control or mask kept through system reset");
  a_mask_sleep_kept: assert property (
    deep_sleep && !sys_rst && !sw_cmd[1].mask_we |=> $stable(mask_reg[1]))
    else $error("mask lost in deep sleep");
  a_irq_write_clears: assert property (
    sw_cmd[0].irq_clr && !cap[0] && !sw_cmd[0].irq_force |=> !irq_reg[0])
    else $error("interrupt not cleared by write");
  a_pending_set: assert property (
    !sys_rst && !deep_sleep |=> (pending_reg & $past(fault_set)) == $past(fault_set))
    else $error("fault event not pending");
  a_mirror_view: assert property (
    sw_view[0].pending_fault_vector == sw_view[1].pending_fault_vector)
    else $error("pending views differ");
  a_valid_clear: assert property (
    sw_cmd[1].status_clr && !cap[1] |=> !valid_reg[1])
    else $error("valid not cleared by status write");
  a_out_gated_off: assert property (
    !ctl_reg[0][CTL_OUT] |=> !fout_reg[0])
    else $error("fault output without output enable");
  a_trig_gated_off: assert property (
    !ctl_reg[1][CTL_TRIG] |=> !trig_reg[1])
    else $error("dma trigger without trigger enable");
  a_irq_gate_off: assert property (
    !gate_reg[1] |=> !irq_gated_reg[1])
    else $error("gated interrupt while gate is off");
endmodule : fmon_monitor

/* File: rtl/fmon_pkg.sv */
// package of constants and carriers for the fault report monitor
// assumes one core clock; sources and software sit in the same domain
package fmon_pkg;
  localparam int NSRC        = 96;
  localparam int NSTRUCT     = 2;
  localparam int IDX_W       = 7;
  localparam int WORD_W      = 32;
  localparam int NMASK_WORDS = 3;
  localparam int VALID_BIT   = 31;
  localparam int IRQ_BIT     = 0;
  localparam int CTL_TRIG    = 0;
  localparam int CTL_OUT     = 1;
  localparam int CTL_RST     = 2;
  localparam logic [2:0]        CTL_RESET    = 3'h0;
  localparam logic [NSRC-1:0]   MASK_RESET   = 96'h0;
  localparam logic [WORD_W-1:0] STATUS_RESET = 32'h0;
  localparam logic [WORD_W-1:0] DATA_RESET   = 32'h0;

  // information that a source holds while its fault is pending
  typedef struct packed {
    logic [WORD_W-1:0] data1;
    logic [WORD_W-1:0] data0;
  } fmon_info_t;

  // software command bundle for one structure
  typedef struct packed {
    logic            ctl_we;
    logic [2:0]      ctl;
    logic            mask_we;
    logic [NSRC-1:0] mask;
    logic            gate_we;
    logic            gate;
    logic            status_clr;
    logic            irq_clr;
    logic            irq_force;
  } fmon_cmd_t;

  // state seen by software and system for one structure
  typedef struct packed {
    logic [WORD_W-1:0] status;
    fmon_info_t        info;
    logic [2:0]        ctl;
    logic [NSRC-1:0]   mask;
    logic              gate;
    logic              irq;
    logic              irq_gated;
    logic              dma_trigger_out;
    logic              fault_out;
    logic [NSRC-1:0]   pending_fault_vector;
  } fmon_view_t;
endpackage : fmon_pkg

/* File: verif/fmon_src_model.sv */
// fault source model: raises fault events and holds their information
// assumes the bench drives req just after a rising edge of core_clk
`timescale 1ns/1ps
module fmon_src_model
  import fmon_pkg::*;
(
  input  wire logic [fmon_pkg::NSRC-1:0]            req,
  output logic [fmon_pkg::NSRC-1:0]                 fault_set,
  output fmon_pkg::fmon_info_t [fmon_pkg::NSRC-1:0] fault_info
);
  assign fault_set = req;
  // info is constant per source, so it stays put while pending
  always_comb begin
    for (int n = 0; n < NSRC; n++) begin
      fault_info[n].data0 = 32'hc0de0000 | 32'(n);
      fault_info[n].data1 = ~(32'hc0de0000 | 32'(n));
    end
  end
endmodule : fmon_src_model

/* File: verif/testbench.sv */
// self-checking bench for the fault report monitor
// assumes one core clock; sources modelled, software driven here
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin \
  mismatches++; $display("CHECK FAILED %s exp %h got %h", nm, ex, got); \
  end end
module testbench;
  import fmon_pkg::*;
  localparam logic [NSRC-1:0] M5_70 = (96'h1 << 5) | (96'h1 << 70);
  logic                     core_clk   = 1'b0;
  logic                     rst_n      = 1'b0;
  logic                     sys_rst    = 1'b0;
  logic                     deep_sleep = 1'b0;
  logic [NSRC-1:0]          req        = '0;
  logic [NSRC-1:0]          fault_set;
  fmon_info_t [NSRC-1:0]    fault_info;
  fmon_cmd_t [NSTRUCT-1:0]  sw_cmd     = '0;
  fmon_view_t [NSTRUCT-1:0] sw_view;
  logic [NSRC-1:0]          fault_ack;
  logic [NSRC-1:0]          bus_err;
  logic                     soft_reset_req;
  int                       mismatches = 0;
  int                       compares   = 0;
  wire [3:0] outs0 = {sw_view[0].irq_gated, sw_view[0].dma_trigger_out,
                      sw_view[0].fault_out, soft_reset_req};
  always #5 core_clk = ~core_clk;
  fmon_src_model src (.req(req), .fault_set(fault_set),
                      .fault_info(fault_info));
  fmon_monitor dut (.core_clk(core_clk), .rst_n(rst_n), .sys_rst(sys_rst),
    .deep_sleep(deep_sleep), .fault_set(fault_set),
    .fault_info(fault_info), .sw_cmd(sw_cmd), .sw_view(sw_view),
    .fault_ack(fault_ack), .bus_err(bus_err),
    .soft_reset_req(soft_reset_req));
  function automatic logic [WORD_W-1:0] stat(input int n);
    stat = {1'b1, 24'h0, 7'(n)};
  endfunction : stat
  function automatic fmon_info_t info(input int n);
    info.data0 = 32'hc0de0000 | 32'(n);
    info.data1 = ~info.data0;
  endfunction : info
  task automatic tick();
    @(posedge core_clk);
    #1;
  endtask : tick
  task automatic print_verdict();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : print_verdict
  task automatic cmd(input int s, input fmon_cmd_t c);
    sw_cmd[s] = c;
    tick();
    sw_cmd[s] = '0;
    tick();
  endtask : cmd
  task automatic fire(input logic [NSRC-1:0] v);
    req = v;
    tick();
    `CHK("bus_err", v, bus_err)
    req = '0;
  endtask : fire
  task automatic wait_valid(input int s);
    int k;
    k = 0;
    while (sw_view[s].status[VALID_BIT] !== 1'b1 && k < 20) begin
      tick();
      k++;
    end
    if (k == 20) begin
      mismatches++;
      print_verdict();
    end
  endtask : wait_valid
  initial begin
    repeat (20) @(posedge core_clk);
    #1 rst_n = 1'b1;
    `CHK("status", STATUS_RESET, sw_view[0].status)
    `CHK("ctl", CTL_RESET, sw_view[1].ctl)
    `CHK("mask", MASK_RESET, sw_view[1].mask)
    $display("test reset done");
    cmd(0, '{gate_we:1'b1, gate:1'b1, default:'0});
    cmd(0, '{irq_clr:1'b1, default:'0});
    cmd(0, '{ctl_we:1'b1, ctl:3'h7, default:'0});
    cmd(0, '{status_clr:1'b1, default:'0});
    cmd(0, '{mask_we:1'b1, mask:(96'h1 << 33), default:'0});
    fire(96'h1 << 33);
    `CHK("pend", 32'h2, sw_view[1].pending_fault_vector[63:32])
    `CHK("pend0", 96'h1 << 33, sw_view[0].pending_fault_vector)
    wait_valid(0);
    `CHK("status", stat(33), sw_view[0].status)
    `CHK("info", info(33), sw_view[0].info)
    `CHK("pclr", 96'h0, sw_view[1].pending_fault_vector)
    `CHK("irq", 1'b1, sw_view[0].irq)
    `CHK("ack", 96'h1 << 33, fault_ack)
    tick();
    `CHK("ackdrop", 96'h0, fault_ack)
    `CHK("outs", 4'hf, outs0)
    $display("test capture done");
    cmd(0, '{status_clr:1'b1, default:'0});
    cmd(1, '{mask_we:1'b1, mask:(96'h1 << 5), default:'0});
    cmd(0, '{mask_we:1'b1, mask:M5_70, default:'0});
    fire(M5_70);
    wait_valid(0);
    `CHK("win", stat(5), sw_view[0].status)
    `CHK("lose", STATUS_RESET, sw_view[1].status)
    `CHK("left", 96'h1 << 70, sw_view[0].pending_fault_vector)
    repeat (3) tick();
    `CHK("hold", stat(5), sw_view[0].status)
    cmd(0, '{status_clr:1'b1, default:'0});
    wait_valid(0);
    `CHK("next", stat(70), sw_view[0].status)
    `CHK("info70", info(70), sw_view[0].info)
    $display("test precedence done");
    cmd(0, '{irq_clr:1'b1, default:'0});
    `CHK("irqclr", 1'b0, sw_view[0].irq)
    `CHK("keep", stat(70), sw_view[0].status)
    cmd(0, '{irq_force:1'b1, default:'0});
    `CHK("force", 1'b1, sw_view[0].irq)
    $display("test interrupt done");
    cmd(1, '{ctl_we:1'b1, ctl:3'h2, default:'0});
    fire(96'h1 << 5);
    wait_valid(1);
    `CHK("second", stat(5), sw_view[1].status)
    `CHK("first", stat(70), sw_view[0].status)
    `CHK("info5", info(5), sw_view[1].info)
    tick();
    `CHK("fout1", 1'b1, sw_view[1].fault_out)
    cmd(1, '{status_clr:1'b1, default:'0});
    `CHK("vclr1", 1'b0, sw_view[1].status[VALID_BIT])
    `CHK("fout1clr", 1'b0, sw_view[1].fault_out)
    $display("test second structure done");
    fire(96'h1 << 40);
    deep_sleep = 1'b1;
    tick();
    `CHK("sleep", 96'h0, sw_view[0].pending_fault_vector)
    `CHK("irqds", 1'b0, sw_view[0].irq)
    `CHK("ctlds", 3'h7, sw_view[0].ctl)
    `CHK("maskds", 96'h1 << 5, sw_view[1].mask)
    `CHK("gateds", 1'b1, sw_view[0].gate)
    deep_sleep = 1'b0;
    sys_rst = 1'b1;
    tick();
    sys_rst = 1'b0;
    `CHK("ctlsr", CTL_RESET, sw_view[0].ctl)
    `CHK("masksr", MASK_RESET, sw_view[1].mask)
    `CHK("gatesr", 1'b0, sw_view[0].gate)
    `CHK("statsr", stat(70), sw_view[0].status)
    rst_n = 1'b0;
    tick();
    `CHK("stathr", STATUS_RESET, sw_view[0].status)
    `CHK("infohr", {DATA_RESET, DATA_RESET}, sw_view[0].info)
    $display("test retention done");
    print_verdict();
  end
endmodule : testbench
